//--- rtl/gsw_status_bank.sv
// Global status flags and write transfer counter of the register bank.
// Assumes the frame engine presents one-cycle access strobes after checksum and
// address checks, synchronous to clk_i.
// Function
// RL1 - A fault flag clear is ignored while any fault condition is still active.
// RL2 - Status bit 2 shows the comparator, one while the supply is below 3.5V.
// RL3 - The supply low bit is not latched and needs no clear.
// RL4 - The 8-bit counter at address 0x02 counts each successful write access.
// RL5 - Read accesses leave the counter unchanged.
// RL6 - The counter wraps from 255 to 0.
// RL7 - Latched flags clear on a written one and keep their value on a zero.
// RL8 - The fault flag sets when the power stage shuts down on fault.
// RL9 - Bit 0 is set after reset and shows a reset since the last status access; a status write with bit 0 zero leaves it set.
// RL10 - The counter resets to zero and rejected writes do not count.
module gsw_status_bank
  import gsw_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic wr_ok_i,
  input wire logic wr_reject_i,
  input wire logic rd_ok_i,
  input wire logic [6:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic overtemp_shutdown_i,
  input wire logic short_shutdown_i,
  input wire logic supply_low_indicator_i,
  output logic [7:0] rdata_o,
  output logic drv_fault_o
);
  // ==========================================================================
  // Access decode
  logic status_wr;
  logic status_rd;
  logic fault_active;
  logic reset_flag;
  logic fault_flag;
  logic rst_flag_clr;
  logic count_step;
  logic [GSW_STATUS_W-1:0] flags;
  logic [7:0] write_transfer_count;
  assign status_wr = wr_ok_i && (addr_i == GSW_ADDR_GLOBAL_STATUS);
  assign status_rd = rd_ok_i && (addr_i == GSW_ADDR_GLOBAL_STATUS);
  assign fault_active = overtemp_shutdown_i | short_shutdown_i;
  assign rst_flag_clr = status_rd || (status_wr && wdata_i[GSW_BIT_RESET]);
  assign count_step = wr_ok_i && !wr_reject_i;
  // ==========================================================================
  // Reset flag
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      reset_flag <= GSW_STATUS_RST[GSW_BIT_RESET]; // RL9
    end
    else if (rst_flag_clr)
    begin
      reset_flag <= 1'b0; // RL7 RL9
    end
  end
  // ==========================================================================
  // Driver fault flag
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      fault_flag <= GSW_STATUS_RST[GSW_BIT_DRV_FAULT];
    end
    else if (fault_active)
    begin
      fault_flag <= 1'b1; // RL8 RL1
    end
    else if (status_wr && wdata_i[GSW_BIT_DRV_FAULT])
    begin
      fault_flag <= 1'b0; // RL7
    end
  end
  // ==========================================================================
  // Status word, supply low bit live
  always_comb
  begin
    flags = '0;
    flags[GSW_BIT_RESET] = reset_flag; // RL9
    flags[GSW_BIT_DRV_FAULT] = fault_flag; // RL8
    flags[GSW_BIT_SUPPLY_LOW] = supply_low_indicator_i; // RL2 RL3
  end
  // ==========================================================================
  // Write transfer counter
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      write_transfer_count <= GSW_COUNT_RST; // RL10
    end
    else if (count_step)
    begin
      write_transfer_count <= write_transfer_count + GSW_COUNT_STEP; // RL4 RL6 RL5
    end
  end
  // ==========================================================================
  // Read data
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rdata_o <= 8'h00;
    end
    else if (rd_ok_i)
    begin
      case (addr_i)
        GSW_ADDR_GLOBAL_STATUS: rdata_o <= {5'h00, flags};
        GSW_ADDR_WRITE_COUNT: rdata_o <= write_transfer_count;
        default: rdata_o <= 8'h00;
      endcase
    end
  end
  assign drv_fault_o = fault_flag;
  // ==========================================================================
  // Flag assertions
  property p_fault_hold;
    @(posedge clk_i) disable iff (sys_rst_i)
      fault_active |=> drv_fault_o;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault flag cleared while fault active"); // RL1
  property p_clr_blocked;
    @(posedge clk_i) disable iff (sys_rst_i)
      (status_wr && wdata_i[GSW_BIT_DRV_FAULT] && fault_active) |=> drv_fault_o;
  endproperty
  a_clr_blocked: assert property (p_clr_blocked) else $error("fault flag clear not refused"); // RL1
  property p_fault_clear;
    @(posedge clk_i) disable iff (sys_rst_i)
      (status_wr && wdata_i[GSW_BIT_DRV_FAULT] && !fault_active) |=> !drv_fault_o;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault flag not cleared"); // RL7
  property p_fault_keep;
    @(posedge clk_i) disable iff (sys_rst_i)
      (drv_fault_o && !(status_wr && wdata_i[GSW_BIT_DRV_FAULT])) |=> drv_fault_o;
  endproperty
  a_fault_keep: assert property (p_fault_keep) else $error("fault flag lost without clear"); // RL7
  property p_fault_set;
    @(posedge clk_i) disable iff (sys_rst_i)
      $rose(fault_active) |=> drv_fault_o;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault flag not set"); // RL8
  property p_rst_flag;
    @(posedge clk_i) disable iff (sys_rst_i)
      (reset_flag && !status_rd && !(status_wr && wdata_i[GSW_BIT_RESET])) |=> reset_flag;
  endproperty
  a_rst_flag: assert property (p_rst_flag) else $error("reset flag lost"); // RL9
  property p_rst_clear;
    @(posedge clk_i) disable iff (sys_rst_i)
      (status_rd || (status_wr && wdata_i[GSW_BIT_RESET])) |=> !reset_flag;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("reset flag not cleared"); // RL7
  property p_rst_sticky;
    @(posedge clk_i) disable iff (sys_rst_i)
      !reset_flag |=> !reset_flag;
  endproperty
  a_rst_sticky: assert property (p_rst_sticky) else $error("reset flag set without reset"); // RL9
  // ==========================================================================
  // Counter assertions
  property p_count_inc;
    @(posedge clk_i) disable iff (sys_rst_i)
      (wr_ok_i && !wr_reject_i) |=> write_transfer_count == 8'($past(write_transfer_count) + 8'h01);
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("counter did not advance"); // RL4
  property p_count_rd;
    @(posedge clk_i) disable iff (sys_rst_i)
      (rd_ok_i && !wr_ok_i) |=> $stable(write_transfer_count);
  endproperty
  a_count_rd: assert property (p_count_rd) else $error("read changed counter"); // RL5
  property p_count_wrap;
    @(posedge clk_i) disable iff (sys_rst_i)
      (wr_ok_i && !wr_reject_i && write_transfer_count == 8'hFF) |=> write_transfer_count == 8'h00;
  endproperty
  a_count_wrap: assert property (p_count_wrap) else $error("counter did not wrap"); // RL6
  property p_reject;
    @(posedge clk_i) disable iff (sys_rst_i)
      (!wr_ok_i || wr_reject_i) |=> $stable(write_transfer_count);
  endproperty
  a_reject: assert property (p_reject) else $error("rejected write counted"); // RL10
  // ==========================================================================
  // Read data assertions
  property p_supply_live;
    @(posedge clk_i) disable iff (sys_rst_i)
      (status_rd && supply_low_indicator_i) |=> rdata_o[GSW_BIT_SUPPLY_LOW];
  endproperty
  a_supply_live: assert property (p_supply_live) else $error("supply low bit not shown"); // RL2
  property p_supply_rd;
    @(posedge clk_i) disable iff (sys_rst_i)
      status_rd |=> rdata_o[GSW_BIT_SUPPLY_LOW] == $past(supply_low_indicator_i);
  endproperty
  a_supply_rd: assert property (p_supply_rd) else $error("supply low read wrong"); // RL3
  property p_status_rd;
    @(posedge clk_i) disable iff (sys_rst_i)
      status_rd |=> (rdata_o[GSW_BIT_RESET] == $past(reset_flag))
        && (rdata_o[GSW_BIT_DRV_FAULT] == $past(drv_fault_o));
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status flags read wrong"); // RL9
  property p_status_pad;
    @(posedge clk_i) disable iff (sys_rst_i)
      status_rd |=> rdata_o[7:GSW_STATUS_W] == '0;
  endproperty
  a_status_pad: assert property (p_status_pad) else $error("status upper bits not zero");
  property p_count_data;
    @(posedge clk_i) disable iff (sys_rst_i)
      (rd_ok_i && addr_i == GSW_ADDR_WRITE_COUNT) |=> rdata_o == $past(write_transfer_count);
  endproperty
  a_count_data: assert property (p_count_data) else $error("counter read wrong"); // RL4
  property p_unmapped;
    @(posedge clk_i) disable iff (sys_rst_i)
      (rd_ok_i && addr_i != GSW_ADDR_GLOBAL_STATUS && addr_i != GSW_ADDR_WRITE_COUNT) |=> rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rdata_hold;
    @(posedge clk_i) disable iff (sys_rst_i)
      !rd_ok_i |=> $stable(rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without read");
  // ==========================================================================
  // Cover points
  c_wrap: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    write_transfer_count == 8'hFF ##1 write_transfer_count == 8'h00);
  c_fault: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    drv_fault_o ##1 !drv_fault_o);
  c_rst_rd: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    status_rd && reset_flag);
  c_reject: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    wr_ok_i && wr_reject_i);
  c_supply: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    status_rd && supply_low_indicator_i);
endmodule // gsw_status_bank

//--- rtl/gsw_pkg.sv
// Package: register map, field positions and reset values of the status bank.
// Assumes a single clock domain and register access by the frame engine.
package gsw_pkg;
  // ==========================================================================
  // Register addresses
  localparam logic [6:0] GSW_ADDR_GLOBAL_STATUS = 7'h01;
  localparam logic [6:0] GSW_ADDR_WRITE_COUNT = 7'h02;
  // ==========================================================================
  // Status field positions
  localparam int GSW_BIT_RESET = 0;
  localparam int GSW_BIT_DRV_FAULT = 1;
  localparam int GSW_BIT_SUPPLY_LOW = 2;
  localparam int GSW_STATUS_W = 3;
  // ==========================================================================
  // Reset values and counter step
  localparam logic [2:0] GSW_STATUS_RST = 3'h1;
  localparam logic [7:0] GSW_COUNT_RST = 8'h00;
  localparam logic [7:0] GSW_COUNT_STEP = 8'h01;
endpackage : gsw_pkg

//--- verification/gsw_host_model.sv
// Host side model: issues the access strobes of one register access.
// Assumes the bench calls acc and inputs move on the falling clk_i edge.
module gsw_host_model (
  input wire logic clk_i,
  output logic wr_ok_o,
  output logic wr_reject_o,
  output logic rd_ok_o,
  output logic [6:0] addr_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====
  // One access, strobes high one cycle
  initial {wr_ok_o, wr_reject_o, rd_ok_o, addr_o, wdata_o} = '0;
  task automatic acc(input logic w, input logic r, input logic j, input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {wr_ok_o, wr_reject_o, rd_ok_o, addr_o, wdata_o} = {w, j, r, a, d};
    @(negedge clk_i);
    {wr_ok_o, wr_reject_o, rd_ok_o, addr_o, wdata_o} = {3'h0, ~a, ~d};
  endtask
endmodule // gsw_host_model

//--- verification/global_status_and_write_counter_test.sv
// Self-checking bench of the status bank, host model on the access side.
// Assumes read data appears one cycle after the read strobe.
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module global_status_and_write_counter_test
  import gsw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, sys_rst_i = 1, ot = 0, sc = 0, sl = 0, wr_ok, wr_rej, rd_ok, fault;
  logic [6:0] addr;
  logic [7:0] wdata, rdata, cnt = 8'h00, exp_v;
  logic [7:0] exp_q[$];
  int bad_count = 0, samples_checked = 0;
  integer seed = 32'hf35833d6;
  always #25 clk_i = ~clk_i;
  gsw_host_model i_gsw_host_model (.clk_i(clk_i), .wr_ok_o(wr_ok), .wr_reject_o(wr_rej), .rd_ok_o(rd_ok),
    .addr_o(addr), .wdata_o(wdata));
  gsw_status_bank i_gsw_status_bank (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wr_ok_i(wr_ok), .wr_reject_i(wr_rej),
    .rd_ok_i(rd_ok), .addr_i(addr), .wdata_i(wdata), .overtemp_shutdown_i(ot), .short_shutdown_i(sc),
    .supply_low_indicator_i(sl), .rdata_o(rdata), .drv_fault_o(fault));
  // ====
  // Access tasks and read monitor
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic j);
    i_gsw_host_model.acc(1'b1, 1'b0, j, a, d);
    if (!j) cnt++;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_gsw_host_model.acc(1'b0, 1'b1, 1'b0, a, 8'h00);
  endtask
  always @(posedge clk_i)
    if (rd_ok === 1'b1)
    begin
      @(negedge clk_i);
      exp_v = exp_q.pop_front();
      `CHK(rdata, exp_v)
    end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #200000;
    bad_count++;
    give_verdict();
  end
  // ====
  // Main sequence
  initial
  begin
    repeat (10) @(negedge clk_i);
    sys_rst_i = 1'b0;
    rd(GSW_ADDR_GLOBAL_STATUS, 8'h01);
    rd(GSW_ADDR_GLOBAL_STATUS, 8'h00);
    rd(GSW_ADDR_WRITE_COUNT, 8'h00);
    sl = 1'b1;
    rd(GSW_ADDR_GLOBAL_STATUS, 8'h04);
    sl = 1'b0;
    rd(GSW_ADDR_GLOBAL_STATUS, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      {ot, sc} = k ? 2'b01 : 2'b10;
      @(negedge clk_i);
      `CHK(fault, 1'b1)
      wr(GSW_ADDR_GLOBAL_STATUS, 8'h02, 1'b0);
      `CHK(fault, 1'b1)
      {ot, sc} = 2'b00;
      wr(GSW_ADDR_GLOBAL_STATUS, 8'h00, 1'b0);
      `CHK(fault, 1'b1)
      wr(GSW_ADDR_GLOBAL_STATUS, 8'h02, 1'b0);
      `CHK(fault, 1'b0)
    end
    rd(GSW_ADDR_WRITE_COUNT, cnt);
    rd(GSW_ADDR_WRITE_COUNT, cnt);
    wr(GSW_ADDR_WRITE_COUNT, 8'h5A, 1'b1);
    rd(GSW_ADDR_WRITE_COUNT, cnt);
    for (int k = 0; k < 260; k++)
      wr(7'h03, 8'($random(seed)), 1'b0);
    rd(GSW_ADDR_WRITE_COUNT, cnt);
    for (int k = 0; k < 2; k++)
    begin
      ot = 1'b1;
      @(negedge clk_i);
      ot = 1'b0;
      sys_rst_i = 1'b1;
      repeat (2) @(negedge clk_i);
      sys_rst_i = 1'b0;
      cnt = GSW_COUNT_RST;
      `CHK(fault, 1'b0)
      rd(GSW_ADDR_WRITE_COUNT, GSW_COUNT_RST);
      wr(GSW_ADDR_GLOBAL_STATUS, {7'h00, k[0]}, 1'b0);
      rd(GSW_ADDR_GLOBAL_STATUS, {7'h00, !k[0]});
    end
    rd(GSW_ADDR_WRITE_COUNT, cnt);
    rd(7'h05, 8'h00);
    give_verdict();
  end
endmodule // global_status_and_write_counter_test
